// ### common/sram_ctl_pkg.sv
// Package: constants and types for the asynchronous static memory controller
package sram_ctl_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int LANE_W = 8;
   localparam int CLK_PERIOD_PS = 5000;
   // Phase times in ps, chosen with margin for the slowest speed grade
   localparam int T_SETUP_PS  = 5000;
   localparam int T_STROBE_PS = 15000;
   localparam int T_READ_PS   = 20000;
   localparam int T_HOLD_PS   = 5000;
   localparam int T_TURN_PS   = 10000;
   localparam int SETUP_CYC  = (T_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STROBE_CYC = (T_STROBE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int READ_CYC   = (T_READ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HOLD_CYC   = (T_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TURN_CYC   = (T_TURN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
   localparam logic [1:0] BE_NONE = 2'h0;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'b00_0001,
      ST_SETUP  = 6'b00_0010,
      ST_STROBE = 6'b00_0100,
      ST_READ   = 6'b00_1000,
      ST_HOLD   = 6'b01_0000,
      ST_TURN   = 6'b10_0000
   } phase_t;
endpackage

// ### common/phase_timer_if.sv
// Interface: load and expiry of the phase timer
`timescale 1ns/1ps
interface phase_timer_if;
   import sram_ctl_pkg::*;
   logic             load;
   logic [CNT_W-1:0] count;
   logic             done;
   modport ctl (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface

// ### src/phase_timer.sv
// Down counter that flags the end of each bus phase
`timescale 1ns/1ps
module phase_timer (
   input  wire logic   clk_sys_i,
   input  wire logic   rst_i,
   phase_timer_if.tmr  tmr
);
   import sram_ctl_pkg::*;
   logic [CNT_W-1:0] cnt_r;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= CNT_ZERO;
      end else if (tmr.load) begin
         cnt_r <= tmr.count;
      end else if (cnt_r != CNT_ZERO) begin
         cnt_r <= cnt_r - CNT_ONE;
      end
   end

   assign tmr.done = (cnt_r == CNT_ONE) || (cnt_r == CNT_ZERO);
endmodule // phase_timer

// ### src/sram_ctl.sv
// Controller that drives an asynchronous 64K x 16 static memory with byte lanes
// Behaviour
// - Write only while select and strobe low
// - Read: select, output enable low, strobe high
// - Data timed to the write-ending edge
// - Address valid before select falls
`timescale 1ns/1ps
module sram_ctl (
   input  wire logic                        clk_sys_i,
   input  wire logic                        rst_i,
   input  wire logic                        req_valid_i,
   input  wire logic                        req_write_i,
   input  wire logic [sram_ctl_pkg::ADDR_W-1:0] req_addr_i,
   input  wire logic [sram_ctl_pkg::DATA_W-1:0] req_wdata_i,
   input  wire logic [1:0]                  req_be_i,
   output logic                             req_ready_o,
   output logic                             rsp_valid_o,
   output logic [sram_ctl_pkg::DATA_W-1:0]  rsp_rdata_o,
   output logic [sram_ctl_pkg::ADDR_W-1:0]  mem_addr_o,
   output logic                             chip_select_n_o,
   output logic                             write_strobe_n_o,
   output logic                             output_enable_n_o,
   output logic                             low_byte_enable_n_o,
   output logic                             high_byte_enable_n_o,
   input  wire logic [sram_ctl_pkg::DATA_W-1:0] mem_data_i,
   output logic [sram_ctl_pkg::DATA_W-1:0]  mem_data_o,
   output logic [1:0]                       mem_data_oe_o
);
   import sram_ctl_pkg::*;

   // ----------------------------------------------------------------
   // Request capture and phase control
   // ----------------------------------------------------------------
   phase_t             state_r;
   logic               is_write_r;
   logic [1:0]         be_r;
   logic [DATA_W-1:0]  din_s1_r;
   logic [DATA_W-1:0]  din_s2_r;
   phase_timer_if      tmr_if ();

   phase_timer u_timer (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .tmr       (tmr_if.tmr)
   );

   // Requests without a byte enable are dropped: no access happens
   logic take;
   assign take = req_valid_i && req_ready_o && (req_be_i != BE_NONE);

   always_comb begin
      tmr_if.load  = 1'b0;
      tmr_if.count = CNT_ZERO;
      unique case (state_r)
         ST_IDLE: begin
            tmr_if.load  = take;
            tmr_if.count = CNT_W'(SETUP_CYC);
         end
         ST_SETUP: begin
            // Read phase is longer than the write strobe: pick the length by direction
            tmr_if.load  = tmr_if.done;
            tmr_if.count = is_write_r ? CNT_W'(STROBE_CYC) : CNT_W'(READ_CYC);
         end
         ST_STROBE: begin
            tmr_if.load  = tmr_if.done;
            tmr_if.count = CNT_W'(HOLD_CYC);
         end
         ST_READ: begin
            tmr_if.load  = tmr_if.done;
            tmr_if.count = CNT_W'(TURN_CYC);
         end
         ST_HOLD: begin
            tmr_if.load  = tmr_if.done;
            tmr_if.count = CNT_W'(TURN_CYC);
         end
         ST_TURN: begin
            tmr_if.load  = 1'b0;
            tmr_if.count = CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE:   if (take) state_r <= ST_SETUP;
            ST_SETUP:  if (tmr_if.done) state_r <= is_write_r ? ST_STROBE : ST_READ;
            ST_STROBE: if (tmr_if.done) state_r <= ST_HOLD;
            ST_READ:   if (tmr_if.done) state_r <= ST_TURN;
            ST_HOLD:   if (tmr_if.done) state_r <= ST_TURN;
            ST_TURN:   if (tmr_if.done) state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         req_ready_o <= 1'b0;
      end else begin
         req_ready_o <= (state_r == ST_IDLE) && !take;
      end
   end

   // ----------------------------------------------------------------
   // Address, byte lanes and write data
   // ----------------------------------------------------------------
   // Address is set up one phase ahead of select; the lane enables fall together with select
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         mem_addr_o <= ADDR_ZERO;
         is_write_r <= 1'b0;
         be_r       <= BE_NONE;
         mem_data_o <= DATA_ZERO;
      end else if (take) begin
         mem_addr_o <= req_addr_i;
         is_write_r <= req_write_i;
         be_r       <= req_be_i;
         mem_data_o <= req_wdata_i;
      end
   end

   // ----------------------------------------------------------------
   // Memory strobes
   // ----------------------------------------------------------------
   logic active;
   assign active = (state_r == ST_STROBE) || (state_r == ST_READ);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         chip_select_n_o      <= 1'b1;
         write_strobe_n_o     <= 1'b1;
         output_enable_n_o    <= 1'b1;
         low_byte_enable_n_o  <= 1'b1;
         high_byte_enable_n_o <= 1'b1;
      end else begin
         // Select asserted only after address has settled
         chip_select_n_o      <= !(state_r == ST_SETUP && tmr_if.done) && !(active && !tmr_if.done);
         // Strobe opens with select and closes with it; data held past it
         write_strobe_n_o     <= !(is_write_r && ((state_r == ST_SETUP && tmr_if.done)
                                 || (state_r == ST_STROBE && !tmr_if.done)));
         output_enable_n_o    <= !(!is_write_r && ((state_r == ST_SETUP && tmr_if.done)
                                 || (state_r == ST_READ && !tmr_if.done)));
         low_byte_enable_n_o  <= !(be_r[0] && state_r != ST_IDLE && state_r != ST_TURN);
         high_byte_enable_n_o <= !(be_r[1] && state_r != ST_IDLE && state_r != ST_TURN);
      end
   end

   // ----------------------------------------------------------------
   // Data bus drive
   // ----------------------------------------------------------------
   // Drive only in write phases, through hold; never while memory may drive
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         mem_data_oe_o <= BE_NONE;
      end else if (is_write_r && ((state_r == ST_SETUP && tmr_if.done) || state_r == ST_STROBE
                   || (state_r == ST_HOLD && !tmr_if.done))) begin
         mem_data_oe_o <= be_r;
      end else begin
         mem_data_oe_o <= BE_NONE;
      end
   end

   // ----------------------------------------------------------------
   // Read data capture
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         din_s1_r <= DATA_ZERO;
         din_s2_r <= DATA_ZERO;
      end else begin
         din_s1_r <= mem_data_i;
         din_s2_r <= din_s1_r;
      end
   end

   // Sample once read data has passed both synchroniser stages
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rsp_valid_o <= 1'b0;
         rsp_rdata_o <= DATA_ZERO;
      end else begin
         rsp_valid_o <= 1'b0;
         if (state_r == ST_READ && tmr_if.done) begin
            rsp_valid_o <= 1'b1;
            rsp_rdata_o <= {be_r[1] ? din_s2_r[DATA_W-1:LANE_W] : 8'h00,
                            be_r[0] ? din_s2_r[LANE_W-1:0] : 8'h00};
         end else if (state_r == ST_HOLD && tmr_if.done) begin
            rsp_valid_o <= 1'b1;
         end
      end
   end
endmodule // sram_ctl

// ### bench/sram_ctl_checker.sv
// Checker: bus-side timing relations of the static memory controller
`timescale 1ns/1ps
module sram_ctl_checker (
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic [15:0] mem_addr_o,
   input wire logic        chip_select_n_o,
   input wire logic        write_strobe_n_o,
   input wire logic        output_enable_n_o,
   input wire logic        low_byte_enable_n_o,
   input wire logic        high_byte_enable_n_o,
   input wire logic [15:0] mem_data_o,
   input wire logic [1:0]  mem_data_oe_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   property p_wr_sel; !write_strobe_n_o |-> !chip_select_n_o && output_enable_n_o; endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("strobe low outside select");
   property p_rd_dir; !output_enable_n_o |-> !chip_select_n_o && write_strobe_n_o && mem_data_oe_o == 2'h0; endproperty
   a_rd_dir: assert property (p_rd_dir) else $error("read with bus driven");
   property p_lanes; !write_strobe_n_o |-> mem_data_oe_o == ~{high_byte_enable_n_o, low_byte_enable_n_o}; endproperty
   a_lanes: assert property (p_lanes) else $error("write lanes differ from enables");
   property p_no_lane; !chip_select_n_o |-> !(low_byte_enable_n_o && high_byte_enable_n_o); endproperty
   a_no_lane: assert property (p_no_lane) else $error("select without lane");
   property p_addr; !chip_select_n_o |-> $stable(mem_addr_o); endproperty
   a_addr: assert property (p_addr) else $error("address moved while selected");
   property p_strobe; $fell(write_strobe_n_o) |-> !write_strobe_n_o [*3] ##1 write_strobe_n_o; endproperty
   a_strobe: assert property (p_strobe) else $error("strobe width wrong");
   property p_rd_len; $fell(output_enable_n_o) |-> !output_enable_n_o [*4] ##1 output_enable_n_o; endproperty
   a_rd_len: assert property (p_rd_len) else $error("read phase short");
   property p_end; $rose(write_strobe_n_o) |-> $rose(chip_select_n_o) && $stable(mem_data_o); endproperty
   a_end: assert property (p_end) else $error("write end not joint");
   property p_hold; $rose(write_strobe_n_o) |-> mem_data_oe_o != 2'h0 ##[1:2] mem_data_oe_o == 2'h0; endproperty
   a_hold: assert property (p_hold) else $error("data hold wrong");
endmodule // sram_ctl_checker
bind sram_ctl sram_ctl_checker chk_u (.clk_sys_i, .rst_i, .mem_addr_o, .chip_select_n_o, .write_strobe_n_o,
   .output_enable_n_o, .low_byte_enable_n_o, .high_byte_enable_n_o, .mem_data_o, .mem_data_oe_o);

// ### bench/sram_model.sv
// Partner model: asynchronous 64K x 16 static memory with byte lanes
`timescale 1ns/1ps
module sram_model (
   input  wire logic        clk_sys_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        chip_select_n_i,
   input  wire logic        write_strobe_n_i,
   input  wire logic        output_enable_n_i,
   input  wire logic        low_byte_enable_n_i,
   input  wire logic        high_byte_enable_n_i,
   input  wire logic [15:0] data_i,
   output logic      [15:0] data_o,
   output logic      [1:0]  data_oe_o
);
   logic [15:0] mem [65536];
   logic        rd;
   assign rd = !chip_select_n_i && !output_enable_n_i && write_strobe_n_i;
   assign data_oe_o = {rd && !high_byte_enable_n_i, rd && !low_byte_enable_n_i};
   assign data_o = mem[addr_i];
   // Write overlap sampled each cycle; the last sample before the end wins
   always @(posedge clk_sys_i) begin
      if (!chip_select_n_i && !write_strobe_n_i) begin
         if (!low_byte_enable_n_i) mem[addr_i][7:0] <= data_i[7:0];
         if (!high_byte_enable_n_i) mem[addr_i][15:8] <= data_i[15:8];
      end
   end
endmodule // sram_model

// ### bench/sram_ctl_bench.sv
// Testbench: request-side scenarios of the static memory controller
`timescale 1ns/1ps
module sram_ctl_bench;
   import sram_ctl_pkg::*;
   logic              clk_sys_i, rst_i, req_valid_i, req_write_i, req_ready_o, rsp_valid_o, seen;
   logic              cs_n, we_n, oe_n, lbe_n, hbe_n;
   logic [DATA_W-1:0] req_wdata_i, rsp_rdata_o, mem_data_o, bus, last, rd_d;
   logic [ADDR_W-1:0] req_addr_i, mem_addr_o;
   logic [1:0]        req_be_i, mem_data_oe_o, rd_oe;
   int                fail_count = 0;
   int                checks = 0;
   sram_ctl dut_u (.clk_sys_i, .rst_i, .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i, .req_be_i,
      .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .mem_addr_o, .chip_select_n_o(cs_n), .write_strobe_n_o(we_n),
      .output_enable_n_o(oe_n), .low_byte_enable_n_o(lbe_n), .high_byte_enable_n_o(hbe_n),
      .mem_data_i(bus), .mem_data_o, .mem_data_oe_o);
   sram_model mem_u (.clk_sys_i, .addr_i(mem_addr_o), .chip_select_n_i(cs_n), .write_strobe_n_i(we_n),
      .output_enable_n_i(oe_n), .low_byte_enable_n_i(lbe_n), .high_byte_enable_n_i(hbe_n),
      .data_i(bus), .data_o(rd_d), .data_oe_o(rd_oe));
   // Undriven lanes show the inverse of their last level
   assign bus[7:0] = mem_data_oe_o[0] ? mem_data_o[7:0] : rd_oe[0] ? rd_d[7:0] : ~last[7:0];
   assign bus[15:8] = mem_data_oe_o[1] ? mem_data_o[15:8] : rd_oe[1] ? rd_d[15:8] : ~last[15:8];
   always @(posedge clk_sys_i) last <= bus;
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic req(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [1:0] be,
                      input logic rsp);
      seen = 1'b0;
      do @(negedge clk_sys_i); while (req_ready_o !== 1'b1);
      @(posedge clk_sys_i);
      req_valid_i <= 1'b1;
      req_write_i <= w;
      req_addr_i <= a;
      req_wdata_i <= d;
      req_be_i <= be;
      @(posedge clk_sys_i);
      req_valid_i <= 1'b0;
      @(negedge clk_sys_i);
      chk("req_ready_busy", {15'h0000, be == 2'h0}, {15'h0000, req_ready_o});
      for (int i = 0; i < 20 && !seen; i++) begin
         @(negedge clk_sys_i);
         seen = (rsp_valid_o === 1'b1);
      end
      chk("rsp_valid", {15'h0000, rsp}, {15'h0000, seen});
   endtask
   task automatic t_word;
      req(1'b1, 16'h0000, 16'hA5C3, 2'h3, 1'b1);
      chk("mem_word", 16'hA5C3, mem_u.mem[0]);
      req(1'b0, 16'h0000, 16'h0000, 2'h3, 1'b1);
      chk("rdata_word", 16'hA5C3, rsp_rdata_o);
   endtask
   task automatic t_lanes;
      req(1'b1, 16'hFFFF, 16'h1234, 2'h3, 1'b1);
      req(1'b1, 16'hFFFF, 16'h55AB, 2'h1, 1'b1);
      chk("mem_low", 16'h12AB, mem_u.mem[16'hFFFF]);
      req(1'b1, 16'hFFFF, 16'hCD99, 2'h2, 1'b1);
      chk("mem_high", 16'hCDAB, mem_u.mem[16'hFFFF]);
      req(1'b0, 16'hFFFF, 16'h0000, 2'h1, 1'b1);
      chk("rdata_low", 16'h00AB, rsp_rdata_o);
      req(1'b0, 16'hFFFF, 16'h0000, 2'h2, 1'b1);
      chk("rdata_high", 16'hCD00, rsp_rdata_o);
   endtask
   task automatic t_none;
      req(1'b1, 16'h0000, 16'hFFFF, 2'h0, 1'b0);
      chk("mem_none", 16'hA5C3, mem_u.mem[0]);
      req(1'b0, 16'h0000, 16'h0000, 2'h0, 1'b0);
      chk("rdata_none", 16'hCD00, rsp_rdata_o);
   endtask
   task automatic t_reset;
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      @(negedge clk_sys_i);
      chk("ready_in_reset", 16'h0000, {15'h0000, req_ready_o});
      chk("pins_in_reset", 16'h001F, {9'h000, mem_data_oe_o, cs_n, we_n, oe_n, lbe_n, hbe_n});
      @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(negedge clk_sys_i);
      chk("ready_release", 16'h0000, {15'h0000, req_ready_o});
      @(negedge clk_sys_i);
      chk("ready_after", 16'h0001, {15'h0000, req_ready_o});
      req(1'b0, 16'h0000, 16'h0000, 2'h3, 1'b1);
      chk("rdata_after_reset", 16'hA5C3, rsp_rdata_o);
   endtask
   task automatic summarize;
      if (fail_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      rst_i = 1'b1;
      req_valid_i = 1'b0;
      req_write_i = 1'b0;
      req_addr_i = 16'h0000;
      req_wdata_i = 16'h0000;
      req_be_i = 2'h0;
      repeat (20) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_word();
      t_lanes();
      t_none();
      t_reset();
      summarize();
   end
   initial begin
      repeat (4000) @(posedge clk_sys_i);
      fail_count++;
      summarize();
   end
endmodule // sram_ctl_bench
